// [dv/hbm_enc_model.sv]
// Purpose: Motor encoder model
// Assumes: Pulse period given in clocks
// Notes: Line idles low while stopped
`timescale 1ns/1ns
module hbm_enc_model (
  input wire logic hclk,
  input wire logic run,
  input wire logic [15:0] period,
  output logic pulse
);
  logic [15:0] cnt = 16'h0000;
  initial pulse = 1'b0;
  always @(posedge hclk) begin
    cnt <= (!run || cnt >= period - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
    pulse <= run && cnt < 16'h0004;
  end
endmodule

// [dv/hbm_top_bench.sv]
// Purpose: Bench for hbm_top
// Assumes: 20 MHz clock
// Notes: Bench sets the encoder model pulse period
`timescale 1ns/1ns
module hbm_top_bench;
  logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, run = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0] htrans = '0;
  logic [15:0] per = 16'h00C8;
  logic rdy, hresp, enc, pwm, dir, done;
  int n_mismatch = 0, checks = 0, k, hi;
  hbm_top u_hbm_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(rdy), .hrdata, .hreadyout(rdy), .hresp, .encoder_pulse(enc),
    .bridge_pwm(pwm), .bridge_dir(dir), .measure_done(done));
  hbm_enc_model u_hbm_enc_model (.hclk, .run, .period(per), .pulse(enc));
  initial begin
    forever #25 hclk = ~hclk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do @(posedge hclk); while (rdy !== 1'b1 && ++n < 20);
    if (n == 20) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    haddr <= {24'h00_0000, ad};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    r = hrdata;
  endtask
  task automatic t_regs;
    check("dir_reset", dir, 0);
    check("pwm_reset", pwm, 0);
    for (int i = 0; i < 24; i += 4) begin
      bus(1'b0, i[7:0], '0);
      check("reset_read", r, '0);
      bus(1'b1, i[7:0], 32'hFFFF_FFFF);
      bus(1'b0, i[7:0], '0);
      check("ones_read", r, i > 12 ? 0 : i == 8 ? 32'h0000_03FF : 1);
    end
    check("dir_pin", dir, 1);
    check("hresp_okay", hresp, 0);
    $display("register test done");
  endtask
  task automatic pwm_cnt(input logic [9:0] d, input logic e, input int exp);
    bus(1'b1, 8'h00, {31'h0, e});
    bus(1'b1, 8'h08, {22'h0, d});
    repeat (1100) @(posedge hclk);
    hi = 0;
    repeat (1024) begin
      @(posedge hclk);
      hi += pwm;
    end
    check("pwm_high", hi, exp);
  endtask
  task automatic t_pwm;
    pwm_cnt(10'h000, 1'b1, 0);
    pwm_cnt(10'h001, 1'b1, 1);
    pwm_cnt(10'h200, 1'b1, 512);
    pwm_cnt(10'h200, 1'b0, 0);
    $display("pwm test done");
  endtask
  task automatic meas(input logic dn, input logic [15:0] lo, input logic [15:0] up);
    bus(1'b1, 8'h0C, '0);
    bus(1'b1, 8'h0C, 1);
    for (k = 0; k < 3000 && done !== 1'b1; k++) begin
      @(posedge hclk);
    end
    check("done", done, dn);
    if (dn && done !== 1'b1) summarize();
    bus(1'b0, 8'h10, '0);
    check("raw_in_range", r[15:0] >= lo && r[15:0] <= up, 1);
  endtask
  task automatic t_meas;
    bus(1'b1, 8'h00, 1);
    run <= 1'b1;
    meas(1'b1, 16'h0009, 16'h000B);
    hi = r;
    per <= 16'h0190;
    repeat (1000) @(posedge hclk);
    bus(1'b0, 8'h10, '0);
    check("raw_kept", r, hi);
    meas(1'b1, 16'h0013, 16'h0015);
    bus(1'b1, 8'h00, '0);
    meas(1'b0, 16'h0013, 16'h0015);
    $display("measurement test done");
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_pwm();
    t_meas();
    summarize();
  end
endmodule

// [dv/hbm_top_sva.sv]
// Purpose: Port assertions for hbm_top
// Assumes: Zero-wait bus
// Notes: Registers shadowed from bus writes
`timescale 1ns/1ns
module hbm_top_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic bridge_pwm,
  input wire logic bridge_dir,
  input wire logic measure_done
);
  logic wr, rd, en, dir, enc;
  logic [7:0] a;
  logic [9:0] duty;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr, rd, en, dir, enc, a, duty} <= '0;
    end else begin
      wr <= hsel && htrans == 2'h2 && hwrite;
      rd <= hsel && htrans == 2'h2 && !hwrite;
      a <= haddr[7:0];
      if (wr && a == 8'h00) en <= hwdata[0];
      if (wr && a == 8'h04) dir <= hwdata[0];
      if (wr && a == 8'h08) duty <= hwdata[9:0];
      if (wr && a == 8'h0C) enc <= hwdata[0];
    end
  end
  chk_en_read: assert property (rd && a == 8'h00 |-> hrdata[0] == en)
    else $error("enable read wrong");
  chk_dir_pin: assert property (dir == $past(dir) |-> bridge_dir == dir)
    else $error("direction pin wrong");
  chk_duty_read: assert property (rd && a == 8'h08 |-> hrdata[9:0] == duty)
    else $error("duty read wrong");
  chk_done_gate: assert property ($rose(measure_done) |-> en && enc)
    else $error("done without enables");
  chk_raw_upper: assert property (rd |-> hrdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  chk_done_clear: assert property (!enc [*3] |-> !measure_done)
    else $error("done while measure off");
  chk_ctl_upper: assert property (rd && a != 8'h08 && a != 8'h10 |-> hrdata[31:1] == '0)
    else $error("unused bits set");
  chk_pwm_off: assert property (!en [*2] |-> !bridge_pwm)
    else $error("drive while bridge off");
endmodule
bind hbm_top hbm_top_sva u_hbm_top_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hrdata, .bridge_pwm, .bridge_dir, .measure_done);

// [rtl/hbm_consts.svh]
// Purpose: Offsets, fields, reset values and timing for the motor controller
// Assumes: 20 MHz system clock
// Notes: Definitions only
`ifndef HBM_CONSTS_SVH
`define HBM_CONSTS_SVH
`define HBM_OFS_BRIDGE_ENABLE 8'h00
`define HBM_OFS_ROTATION_DIRECTION 8'h04
`define HBM_OFS_SPEED_DUTY 8'h08
`define HBM_OFS_ENCODER_MEASURE_ENABLE 8'h0C
`define HBM_OFS_RAW_SPEED_PERIOD 8'h10
`define HBM_ADDR_MSB 7
`define HBM_DUTY_W 10
`define HBM_RAW_W 16
`define HBM_RST_BIT 1'h0
`define HBM_RST_DUTY 10'h000
`define HBM_RST_RAW 16'h0000
`define HBM_CLK_HZ 20000000
`define HBM_TICK_HZ 1000000
`define HBM_TICK_DIV (`HBM_CLK_HZ / `HBM_TICK_HZ)
`define HBM_TICK_CNT_W 5
`define HBM_HTRANS_NONSEQ 2'h2
`endif

// [rtl/hbm_ctl_if.sv]
// Purpose: Control bundle from register file to PWM generator
// Assumes: Single clock
// Notes: One producer, one consumer
`timescale 1ns/1ns
interface hbm_ctl_if;
  logic enable;
  logic [9:0] duty;
  logic pwm;
  modport src (output enable, output duty, input pwm);
  modport dst (input enable, input duty, output pwm);
endinterface

// [rtl/hbm_pkg.sv]
// Purpose: Types for the motor controller
// Assumes: Nothing
// Notes: Constants live in hbm_consts.svh
package hbm_pkg;
  typedef enum logic [1:0] {
    HBM_MEAS_IDLE = 2'b00,
    HBM_MEAS_ARM = 2'b01,
    HBM_MEAS_COUNT = 2'b10,
    HBM_MEAS_DONE = 2'b11
  } hbm_meas_state_t;
endpackage

// [rtl/hbm_pwm.sv]
// Purpose: 10-bit PWM generator for the bridge drive
// Assumes: Duty steady or changing at any time; compared every clock, takes effect on the next clock
// Notes: Output low while disabled
`timescale 1ns/1ns
`include "hbm_consts.svh"
module hbm_pwm (
  input wire logic hclk,
  input wire logic hresetn,
  hbm_ctl_if.dst ctl
);
  import hbm_pkg::*;
  logic [`HBM_DUTY_W-1:0] cnt;
  logic [`HBM_DUTY_W-1:0] next_cnt;
  logic pwm_q;
  logic next_pwm_q;
  always_comb begin
    next_cnt = ctl.enable ? cnt + 10'h001 : `HBM_RST_DUTY;
    // Duty compare, all ones full on
    next_pwm_q = ctl.enable && ((ctl.duty == 10'h3FF) || (cnt < ctl.duty));
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= `HBM_RST_DUTY;
      pwm_q <= 1'b0;
    end else begin
      cnt <= next_cnt;
      pwm_q <= next_pwm_q;
    end
  end
  assign ctl.pwm = pwm_q;
endmodule

// [rtl/hbm_top.sv]
// Purpose: Single-channel H-bridge motor controller with AHB-Lite registers
// Assumes: Encoder input synchronous to hclk; zero-wait-state slave
// Notes on behaviour
// - Bit 0 at 0x00 is a read/write bridge enable that resets to zero and switches drive.
// - Bit 0 at 0x04 picks clockwise on zero and counter-clockwise on one, reset zero.
// - Bits 9:0 at 0x08 set the PWM duty, all ones maximum and all zeros minimum.
// - Bit 0 at 0x0C starts an encoder measurement, only while the bridge is enabled.
// - Bits 15:0 at 0x10 read the measured value, upper bits zero, writes ignored.
// - The measured value is the encoder pulse period counted in 1 MHz ticks.
// - One value per enable; software clears and sets the enable again for another.
// - Bits above each field are ignored on write and read as zero.
`timescale 1ns/1ns
`include "hbm_consts.svh"
module hbm_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic encoder_pulse,
  output logic bridge_pwm,
  output logic bridge_dir,
  output logic measure_done
);
  import hbm_pkg::*;

  // Bus data phase capture
  logic wr_pend;
  logic next_wr_pend;
  logic [`HBM_ADDR_MSB:0] wr_addr;
  logic [`HBM_ADDR_MSB:0] next_wr_addr;
  logic access;
  assign access = hsel && hready && (htrans == `HBM_HTRANS_NONSEQ);

  // Registers
  logic bridge_enable;
  logic next_bridge_enable;
  logic rotation_direction;
  logic next_rotation_direction;
  logic [`HBM_DUTY_W-1:0] speed_duty;
  logic [`HBM_DUTY_W-1:0] next_speed_duty;
  logic encoder_measure_enable;
  logic next_encoder_measure_enable;
  logic [`HBM_RAW_W-1:0] raw_speed_period;
  logic [`HBM_RAW_W-1:0] next_raw_speed_period;
  logic [31:0] next_hrdata;

  // Measurement state
  hbm_meas_state_t state;
  hbm_meas_state_t next_state;
  logic [`HBM_TICK_CNT_W-1:0] div_cnt;
  logic [`HBM_TICK_CNT_W-1:0] next_div_cnt;
  logic tick;
  logic [`HBM_RAW_W-1:0] period_cnt;
  logic [`HBM_RAW_W-1:0] next_period_cnt;
  logic enc_q;
  logic next_enc_q;
  logic enc_rise;

  always_comb begin
    next_wr_pend = access && hwrite;
    next_wr_addr = haddr[`HBM_ADDR_MSB:0];
    next_bridge_enable = bridge_enable;
    next_rotation_direction = rotation_direction;
    next_speed_duty = speed_duty;
    next_encoder_measure_enable = encoder_measure_enable;
    if (wr_pend) begin
      case (wr_addr)
        `HBM_OFS_BRIDGE_ENABLE: begin
          next_bridge_enable = hwdata[0];
        end
        `HBM_OFS_ROTATION_DIRECTION: begin
          next_rotation_direction = hwdata[0];
        end
        `HBM_OFS_SPEED_DUTY: begin
          next_speed_duty = hwdata[`HBM_DUTY_W-1:0];
        end
        `HBM_OFS_ENCODER_MEASURE_ENABLE: begin
          next_encoder_measure_enable = hwdata[0];
        end
        default: begin
          next_bridge_enable = bridge_enable;
        end
      endcase
    end
    next_hrdata = hrdata;
    if (access && !hwrite) begin
      case (haddr[`HBM_ADDR_MSB:0])
        `HBM_OFS_BRIDGE_ENABLE: begin
          next_hrdata = {31'h0000_0000, bridge_enable};
        end
        `HBM_OFS_ROTATION_DIRECTION: begin
          next_hrdata = {31'h0000_0000, rotation_direction};
        end
        `HBM_OFS_SPEED_DUTY: begin
          next_hrdata = {22'h00_0000, speed_duty};
        end
        `HBM_OFS_ENCODER_MEASURE_ENABLE: begin
          next_hrdata = {31'h0000_0000, encoder_measure_enable};
        end
        `HBM_OFS_RAW_SPEED_PERIOD: begin
          next_hrdata = {16'h0000, raw_speed_period};
        end
        default: begin
          next_hrdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= `HBM_OFS_BRIDGE_ENABLE;
      bridge_enable <= `HBM_RST_BIT;
      rotation_direction <= `HBM_RST_BIT;
      speed_duty <= `HBM_RST_DUTY;
      encoder_measure_enable <= `HBM_RST_BIT;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      bridge_enable <= next_bridge_enable;
      rotation_direction <= next_rotation_direction;
      speed_duty <= next_speed_duty;
      encoder_measure_enable <= next_encoder_measure_enable;
      hrdata <= next_hrdata;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Measurement: period between two encoder rising edges
  assign enc_rise = encoder_pulse && !enc_q;
  assign tick = (div_cnt == `HBM_TICK_CNT_W'(`HBM_TICK_DIV - 1));

  always_comb begin
    next_enc_q = encoder_pulse;
    next_div_cnt = tick ? '0 : div_cnt + 5'h01;
    next_state = state;
    next_period_cnt = period_cnt;
    next_raw_speed_period = raw_speed_period;
    case (state)
      HBM_MEAS_IDLE: begin
        if (encoder_measure_enable && bridge_enable) begin
          next_state = HBM_MEAS_ARM;
        end
      end
      HBM_MEAS_ARM: begin
        if (enc_rise) begin
          next_state = HBM_MEAS_COUNT;
          next_period_cnt = `HBM_RST_RAW;
        end
      end
      HBM_MEAS_COUNT: begin
        if (enc_rise) begin
          next_state = HBM_MEAS_DONE;
          next_raw_speed_period = period_cnt;
        end else if (tick && period_cnt != 16'hFFFF) begin
          next_period_cnt = period_cnt + 16'h0001;
        end
      end
      HBM_MEAS_DONE: begin
        if (!encoder_measure_enable) begin
          next_state = HBM_MEAS_IDLE;
        end
      end
      default: begin
        next_state = HBM_MEAS_IDLE;
      end
    endcase
    if (!bridge_enable && (state == HBM_MEAS_ARM || state == HBM_MEAS_COUNT)) begin
      next_state = HBM_MEAS_IDLE;
    end
    if (!bridge_enable && state == HBM_MEAS_DONE && !encoder_measure_enable) begin
      next_state = HBM_MEAS_IDLE;
    end
    // Clearing enable drops a pending run
    if (!encoder_measure_enable && (state == HBM_MEAS_ARM || state == HBM_MEAS_COUNT)) begin
      next_state = HBM_MEAS_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= HBM_MEAS_IDLE;
      div_cnt <= '0;
      period_cnt <= `HBM_RST_RAW;
      raw_speed_period <= `HBM_RST_RAW;
      enc_q <= 1'b0;
    end else begin
      state <= next_state;
      div_cnt <= next_div_cnt;
      period_cnt <= next_period_cnt;
      raw_speed_period <= next_raw_speed_period;
      enc_q <= next_enc_q;
    end
  end

  // PWM stage
  hbm_ctl_if ctl ();
  assign ctl.enable = bridge_enable;
  assign ctl.duty = speed_duty;
  hbm_pwm u_pwm (
    .hclk(hclk),
    .hresetn(hresetn),
    .ctl(ctl.dst)
  );
  assign bridge_pwm = ctl.pwm;
  assign bridge_dir = rotation_direction;
  assign measure_done = (state == HBM_MEAS_DONE);
endmodule
